// *** mesb_regs.svh ***
// Offsets, bit layouts and reset values of the monitor error status bank
`ifndef MESB_REGS_SVH
`define MESB_REGS_SVH
`define MESB_ZONE_REG_OFS   8'h40
`define MESB_LOW_REG_OFS    8'h41
`define MESB_HIGH_REG_OFS   8'h42
`define MESB_FLAG_RESET     24'h000000
`define MESB_BYTE_ZERO      8'h00
`define MESB_IMPL_BITS      24'hFFFF3F
`define MESB_FIXED_MASK     24'h47FF30
`define MESB_OPT_MASK       24'h380003
`define MESB_ZONE_LSB       0
`define MESB_LOW_LSB        8
`define MESB_HIGH_LSB       16
`define MESB_VRD1_BIT       4
`define MESB_VRD2_BIT       5
`define MESB_NUM_ZONES      4
`define MESB_NUM_ANALOG     16
`define MESB_NUM_FLAGS      24
`endif

// *** mesb_pkg.sv ***
// Types shared by the monitor error status bank
package mesb_pkg;
    typedef enum logic [2:0] {
        MESB_S0  = 3'b001,
        MESB_S3  = 3'b010,
        MESB_S45 = 3'b100
    } mesb_sleep_e;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } mesb_req_s;
endpackage

// *** mesb_error_bank.sv ***
// Sticky error status flags for zones, regulator hot inputs and analog inputs
//
// Contract
// - Zone 1 and 2 flags (bits 0,1 of the zone register) set on a zone limit violation, optionally masked in S3 and S4/5.
// - Zone 3 and 4 flags (bits 2,3) set on a zone limit violation and are never masked.
// - Bit 4 sets while the first regulator hot input is high and is masked in S3 and S4/5.
// - Bit 5 sets while the active-low second regulator hot input is low and is masked in S3 and S4/5.
// - Bit n-1 of the low analog register sets when analog input n is out of range, masked in S3 and S4/5.
// - Bits 0 to 2 of the high analog register follow inputs 9 to 11, masked in S3 and S4/5.
// - Bits 3 to 5 of the high analog register follow inputs 12 to 14, optionally masked in S3 and S4/5.
// - Bit 6 of the high analog register follows input 15 and is always masked in S3 and S4/5.
// - Bit 7 of the high analog register follows input 16 and is never masked.
// - A flag holds until cleared, and a clear loses to a condition that persists unmasked.
// - In ASF mode a read or a write of one clears flags; otherwise only a write of one does.
// - The summary error bit is set while any flag is set and drives the alert when enabled.
// - Optional masking in the current sleep state comes from the per-state sleep mask inputs.
`timescale 1ns/10ps
`include "mesb_regs.svh"
module mesb_error_bank
    import mesb_pkg::*;
(
    input  wire logic                           SYS_CLK,
    input  wire logic                           RESET_N,
    input  wire mesb_req_s                      REG_REQ,
    output logic [7:0]                          REG_RDATA,
    input  wire logic [`MESB_NUM_ZONES-1:0]     ZONE_LIMIT_FAULT,
    input  wire logic [`MESB_NUM_ANALOG-1:0]    ANALOG_RANGE_FAULT,
    input  wire logic                           REGULATOR_ONE_HOT_IN,
    input  wire logic                           REGULATOR_TWO_HOT_IN_N,
    input  wire mesb_sleep_e                    SLEEP_STATE,
    input  wire logic [`MESB_NUM_FLAGS-1:0]     SLEEP_MASK_S3,
    input  wire logic [`MESB_NUM_FLAGS-1:0]     SLEEP_MASK_S45,
    input  wire logic                           ASF_MODE,
    input  wire logic                           ALERT_EN,
    output logic                                SUMMARY_ERROR_BIT,
    output logic                                ALERT
);
    logic [1:0]                        reg1_sync_ff;
    logic [1:0]                        reg2_sync_n_ff;
    logic [`MESB_NUM_FLAGS-1:0]        flags_ff;
    logic [`MESB_NUM_FLAGS-1:0]        nxt_flags;
    logic [`MESB_NUM_FLAGS-1:0]        cond;
    logic [`MESB_NUM_FLAGS-1:0]        mask;
    logic [`MESB_NUM_FLAGS-1:0]        active;
    logic [`MESB_NUM_FLAGS-1:0]        clr_vec;
    logic [`MESB_NUM_FLAGS-1:0]        sel_vec;
    logic [7:0]                        nxt_rdata;
    logic                              summary_ff;
    logic                              alert_ff;

    // Regulator hot pins come from outside and pass two flip-flops
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            reg1_sync_ff   <= 2'b00;
            reg2_sync_n_ff <= 2'b11;
        end
        else
        begin
            reg1_sync_ff   <= {reg1_sync_ff[0], REGULATOR_ONE_HOT_IN};
            reg2_sync_n_ff <= {reg2_sync_n_ff[0], REGULATOR_TWO_HOT_IN_N};
        end
    end

    // Error conditions in flag order; bits 7:6 have no source
    always_comb
    begin
        cond = `MESB_FLAG_RESET;
        cond[`MESB_ZONE_LSB +: `MESB_NUM_ZONES] = ZONE_LIMIT_FAULT;
        cond[`MESB_VRD1_BIT] = reg1_sync_ff[1];
        cond[`MESB_VRD2_BIT] = ~reg2_sync_n_ff[1];
        cond[`MESB_LOW_LSB +: `MESB_NUM_ANALOG] = ANALOG_RANGE_FAULT;
    end

    // Sleep masking in S3 and S4/5: fixed bits always, optional bits per sleep mask; nothing masked in S0
    always_comb
    begin
        unique case (SLEEP_STATE)
            MESB_S3:  mask = `MESB_FIXED_MASK | (`MESB_OPT_MASK & SLEEP_MASK_S3);
            MESB_S45: mask = `MESB_FIXED_MASK | (`MESB_OPT_MASK & SLEEP_MASK_S45);
            MESB_S0:  mask = `MESB_FLAG_RESET;
            default:  mask = `MESB_FLAG_RESET;
        endcase
        active = cond & ~mask & `MESB_IMPL_BITS;
    end

    // Byte select of the addressed register
    always_comb
    begin
        sel_vec = `MESB_FLAG_RESET;
        unique case (REG_REQ.addr)
            `MESB_ZONE_REG_OFS: sel_vec[`MESB_ZONE_LSB +: 8] = 8'hFF;
            `MESB_LOW_REG_OFS:  sel_vec[`MESB_LOW_LSB +: 8]  = 8'hFF;
            `MESB_HIGH_REG_OFS: sel_vec[`MESB_HIGH_LSB +: 8] = 8'hFF;
            default:            sel_vec = `MESB_FLAG_RESET;
        endcase
    end

    // Write one clears always, read clears only in ASF mode
    always_comb
    begin
        clr_vec = `MESB_FLAG_RESET;
        if (REG_REQ.wr)
        begin
            clr_vec = sel_vec & {3{REG_REQ.wdata}};
        end
        else if (REG_REQ.rd && ASF_MODE)
        begin
            clr_vec = sel_vec;
        end
        nxt_flags = ((flags_ff & ~clr_vec) | active) & `MESB_IMPL_BITS;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            flags_ff <= `MESB_FLAG_RESET;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end

    // Read data returns the value before any read clear
    always_comb
    begin
        nxt_rdata = `MESB_BYTE_ZERO;
        if (REG_REQ.rd)
        begin
            unique case (REG_REQ.addr)
                `MESB_ZONE_REG_OFS: nxt_rdata = flags_ff[`MESB_ZONE_LSB +: 8];
                `MESB_LOW_REG_OFS:  nxt_rdata = flags_ff[`MESB_LOW_LSB +: 8];
                `MESB_HIGH_REG_OFS: nxt_rdata = flags_ff[`MESB_HIGH_LSB +: 8];
                default:            nxt_rdata = `MESB_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            REG_RDATA <= `MESB_BYTE_ZERO;
        end
        else
        begin
            REG_RDATA <= nxt_rdata;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            summary_ff <= 1'b0;
            alert_ff   <= 1'b0;
        end
        else
        begin
            summary_ff <= |nxt_flags;
            alert_ff   <= (|nxt_flags) & ALERT_EN;
        end
    end

    assign SUMMARY_ERROR_BIT = summary_ff;
    assign ALERT             = alert_ff;

    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    AST_ZONE_OPT_SET: assert property (
        (ZONE_LIMIT_FAULT[0] && SLEEP_STATE == MESB_S0) |=> flags_ff[0])
        else $error("Zone one flag not set");
    AST_ZONE_NEVER_MASKED: assert property (
        (ZONE_LIMIT_FAULT[3] && SLEEP_STATE == MESB_S45) |=> flags_ff[3])
        else $error("Zone four flag masked");
    AST_REG1_MASKED: assert property (
        ((SLEEP_STATE == MESB_S3 || SLEEP_STATE == MESB_S45) && !flags_ff[`MESB_VRD1_BIT])
        |=> !flags_ff[`MESB_VRD1_BIT])
        else $error("Regulator one flag set while masked");
    AST_REG2_SET: assert property (
        (!REGULATOR_TWO_HOT_IN_N && SLEEP_STATE == MESB_S0) [*3]
        |=> flags_ff[`MESB_VRD2_BIT])
        else $error("Regulator two flag not set");
    AST_LOW_SET: assert property (
        (ANALOG_RANGE_FAULT[0] && SLEEP_STATE == MESB_S0) |=> flags_ff[8])
        else $error("Analog one flag not set");
    AST_AD9_MASKED: assert property (
        (SLEEP_STATE == MESB_S3 && !flags_ff[16]) |=> !flags_ff[16])
        else $error("Analog nine flag set while masked");
    AST_AD12_OPT: assert property (
        (ANALOG_RANGE_FAULT[11] && SLEEP_STATE == MESB_S3 && !SLEEP_MASK_S3[19])
        |=> flags_ff[19])
        else $error("Analog twelve flag not set");
    AST_AD15_MASKED: assert property (
        (SLEEP_STATE == MESB_S45 && !flags_ff[22]) |=> !flags_ff[22])
        else $error("Analog fifteen flag set while masked");
    AST_AD16_SET: assert property (
        ANALOG_RANGE_FAULT[15] |=> flags_ff[23])
        else $error("Analog sixteen flag not set");
    AST_CLEAR_LOSES: assert property (
        (ZONE_LIMIT_FAULT[2] && REG_REQ.wr && REG_REQ.addr == `MESB_ZONE_REG_OFS)
        |=> flags_ff[2])
        else $error("Clear won over a live condition");
    AST_READ_KEEPS: assert property (
        (REG_REQ.rd && !REG_REQ.wr && !ASF_MODE)
        |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
        else $error("Read cleared a flag outside ASF mode");
    AST_OPT_MASK: assert property (
        (SLEEP_STATE == MESB_S45 && SLEEP_MASK_S45[0] && !flags_ff[0]) |=> !flags_ff[0])
        else $error("Optional mask ignored");
    AST_SUMMARY: assert property (
        (SUMMARY_ERROR_BIT == (|flags_ff)) && (ALERT == (SUMMARY_ERROR_BIT && $past(ALERT_EN))))
        else $error("Summary or alert wrong");
    AST_RESERVED_ZERO: assert property (
        (REG_REQ.rd && REG_REQ.addr == `MESB_ZONE_REG_OFS) |=> REG_RDATA[7:6] == 2'b00)
        else $error("Reserved bits read nonzero");

    COV_ASF_READ_CLEAR: cover property (
        REG_REQ.rd && ASF_MODE && |flags_ff[`MESB_LOW_LSB +: 8] ##1 flags_ff[15:8] == 8'h00);
    COV_W1C: cover property (REG_REQ.wr && |(flags_ff & clr_vec & ~active));
    COV_ALERT: cover property (!ALERT ##1 ALERT);
endmodule

// *** mesb_host_model.sv ***
// Bus engine model that issues register requests to the error bank
`timescale 1ns/10ps
module mesb_host_model
    import mesb_pkg::*;
(
    input  wire logic sys_clk,
    output mesb_req_s reg_req
);
    initial reg_req = '0;

    // Request held until the next access, launched just after a falling edge
    task automatic access(input logic [7:0] addr, input logic wr, input logic rd,
                          input logic [7:0] wdata);
        @(negedge sys_clk);
        reg_req <= '{addr, wr, rd, wdata};
    endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the monitor error status bank
`timescale 1ns/10ps
`include "mesb_regs.svh"
module tb_top
    import mesb_pkg::*;
;
    logic        SYS_CLK, RESET_N, hot1, hot2_n, asf, alert_en, sum, alert, chk_on;
    logic [3:0]  zone;
    logic [15:0] analog;
    logic [23:0] s3m, s45m, act, nf, exp_flags;
    logic [7:0]  rdata, exp_rdata, addr;
    logic [1:0]  sync1, sync2;
    logic        exp_sum, exp_alert;
    mesb_sleep_e sleep;
    mesb_req_s   req;
    int          failures, samples_checked, op;

    mesb_host_model host_u (.sys_clk(SYS_CLK), .reg_req(req));
    mesb_error_bank dut_u (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_REQ(req), .REG_RDATA(rdata),
        .ZONE_LIMIT_FAULT(zone), .ANALOG_RANGE_FAULT(analog),
        .REGULATOR_ONE_HOT_IN(hot1), .REGULATOR_TWO_HOT_IN_N(hot2_n),
        .SLEEP_STATE(sleep), .SLEEP_MASK_S3(s3m), .SLEEP_MASK_S45(s45m),
        .ASF_MODE(asf), .ALERT_EN(alert_en), .SUMMARY_ERROR_BIT(sum), .ALERT(alert)
    );

    initial
    begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    function automatic logic [23:0] mask_of(mesb_sleep_e s, logic [23:0] a, logic [23:0] b);
        case (s)
            MESB_S3:  return `MESB_FIXED_MASK | (`MESB_OPT_MASK & a);
            MESB_S45: return `MESB_FIXED_MASK | (`MESB_OPT_MASK & b);
            default:  return 24'h000000;
        endcase
    endfunction

    function automatic logic [23:0] place(logic [7:0] a, logic [7:0] m);
        case (a)
            `MESB_ZONE_REG_OFS: return {16'h0000, m};
            `MESB_LOW_REG_OFS:  return {8'h00, m, 8'h00};
            `MESB_HIGH_REG_OFS: return {m, 16'h0000};
            default:            return 24'h000000;
        endcase
    endfunction

    // Reference model of the flag bank, one step per rising edge
    always @(posedge SYS_CLK)
    begin
        act = {analog, 2'b00, sync2, zone};
        nf = exp_flags & place(req.addr, 8'hFF);
        exp_rdata <= (req.rd && !req.wr && RESET_N) ? (nf[7:0] | nf[15:8] | nf[23:16]) : 8'h00;
        nf = (exp_flags & ~place(req.addr, req.wr ? req.wdata : {8{req.rd & asf}}))
            | (act & ~mask_of(sleep, s3m, s45m));
        nf = nf & `MESB_IMPL_BITS & {24{RESET_N}};
        exp_flags <= nf;
        exp_sum <= |nf;
        exp_alert <= (|nf) & alert_en;
        sync1 <= {~hot2_n, hot1};
        sync2 <= sync1;
    end

    task automatic check_byte(logic [7:0] got, logic [7:0] exp);
        if (chk_on)
        begin
            samples_checked++;
            if (got !== exp)
            begin
                failures++;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task automatic check_bit(logic got, logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic stop_test();
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(negedge SYS_CLK)
    begin
        check_byte(rdata, exp_rdata);
        check_bit(sum, exp_sum);
        check_bit(alert, exp_alert);
    end

    initial
    begin
        #(25 * 4000);
        failures++;
        stop_test();
    end

    initial
    begin
        RESET_N = 1'b0; chk_on = 1'b0; failures = 0; samples_checked = 0;
        zone = 4'h0; analog = 16'h0000; hot1 = 1'b0; hot2_n = 1'b1; asf = 1'b0;
        alert_en = 1'b1; sleep = MESB_S0; s3m = 24'h000000; s45m = 24'h000000;
        void'($urandom(32'h7CEB));
        repeat (2) @(negedge SYS_CLK);
        chk_on = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        // Corner cases: clear against live faults, read clear, unmapped places
        host_u.access(8'h40, 1'b0, 1'b1, 8'h00);
        zone = 4'hF;
        sleep = MESB_S3;
        s3m = 24'hFFFFFF;
        host_u.access(8'h40, 1'b1, 1'b0, 8'hFF);
        host_u.access(8'h40, 1'b0, 1'b1, 8'h00);
        asf = 1'b1;
        analog = 16'h8001;
        host_u.access(8'h42, 1'b0, 1'b1, 8'h00);
        host_u.access(8'h43, 1'b1, 1'b0, 8'hFF);
        host_u.access(8'h3F, 1'b0, 1'b1, 8'h00);
        for (int i = 0; i < 3000; i++)
        begin
            op = $urandom % 3;
            if (i inside {[1500:1502]})
                op = 0;
            addr = ($urandom % 4 != 0) ? 8'h40 + 8'($urandom % 3) : 8'($urandom);
            host_u.access(addr, op == 1, op == 2, 8'($urandom));
            zone = 4'($urandom & $urandom & $urandom);
            analog = 16'($urandom & $urandom & $urandom);
            hot1 = ($urandom % 8 == 0) && (i < 1496 || i > 1506);
            hot2_n = ($urandom % 8 != 0) || (i > 1495 && i < 1507);
            RESET_N = !(i inside {[1500:1501]});
            if ($urandom % 64 == 0)
            begin
                sleep = mesb_sleep_e'(3'(3'h1 << ($urandom % 4)));
                s3m = 24'($urandom);
                s45m = 24'($urandom);
                asf = 1'($urandom);
                alert_en = 1'($urandom);
            end
        end
        stop_test();
    end
endmodule
